// ---- design/adc_bus_control.sv ----
// Purpose: Bus-side control of an 8-bit successive-approximation converter.
// Assumes: Strobes, data and channel codes arrive from outside and are synchronised.
// Notes: Analog inputs are modelled as 8-bit codes; the pin driver is outside.
`timescale 1ns/1ps
module adc_bus_control #(
  parameter int unsigned CONV_CYCLES = adc_ctrl_pkg::CONV_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic CS_N,
  input wire logic WR_N,
  input wire logic RD_N,
  input wire logic [7:0] SHARED_DATA_LINES_IN,
  output logic [7:0] SHARED_DATA_LINES_OUT,
  output logic SHARED_DATA_LINES_OE,
  output logic CONVERSION_DONE_N,
  input wire logic [31:0] ANALOG_INPUT_CHANNELS,
  input wire logic [7:0] ANALOG_GROUND
);
  localparam int unsigned STEP_CYCLES = CONV_CYCLES / adc_ctrl_pkg::SAR_BITS;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic adc_ctrl_pkg::mux_sel_type decode_mux(input logic [4:0] lat);
    adc_ctrl_pkg::mux_sel_type s;
    s.mode = adc_ctrl_pkg::MODE_DIFF;
    s.pos_src = {1'b0, lat[adc_ctrl_pkg::SEL_PAIR_BIT], lat[adc_ctrl_pkg::SEL_SWAP_BIT]};
    s.neg_src = {1'b0, lat[adc_ctrl_pkg::SEL_PAIR_BIT], ~lat[adc_ctrl_pkg::SEL_SWAP_BIT]};
    if (lat[adc_ctrl_pkg::SEL_MODE_BIT] && !lat[adc_ctrl_pkg::SEL_PSEUDO_BIT]) begin
      s.mode = adc_ctrl_pkg::MODE_SINGLE;
      s.pos_src = {1'b0, lat[1:0]};
      s.neg_src = adc_ctrl_pkg::SRC_GROUND;
    end else if (lat[adc_ctrl_pkg::SEL_MODE_BIT]) begin
      s.mode = adc_ctrl_pkg::MODE_PSEUDO;
      s.pos_src = {1'b0, lat[1:0]};
      s.neg_src = adc_ctrl_pkg::PSEUDO_REF_CH;
    end
    return s;
  endfunction

  function automatic logic [7:0] pick_code(input logic [2:0] src, input logic [31:0] chans, input logic [7:0] gnd);
    logic [7:0] code;
    code = chans[src[1:0]*8 +: 8];
    if (src == adc_ctrl_pkg::SRC_GROUND) begin
      code = gnd;
    end
    return code;
  endfunction

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  adc_ctrl_pkg::strobe_type strobe_meta_reg;
  adc_ctrl_pkg::strobe_type strobe_sync_reg;
  adc_ctrl_pkg::strobe_type strobe_prev_reg;
  logic [7:0] data_meta_reg;
  logic [7:0] data_sync_reg;
  logic [31:0] chan_meta_reg;
  logic [31:0] chan_sync_reg;
  logic [7:0] gnd_meta_reg;
  logic [7:0] gnd_sync_reg;

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      strobe_meta_reg <= '1;
      strobe_sync_reg <= '1;
      strobe_prev_reg <= '1;
      data_meta_reg <= '0;
      data_sync_reg <= '0;
      chan_meta_reg <= '0;
      chan_sync_reg <= '0;
      gnd_meta_reg <= '0;
      gnd_sync_reg <= '0;
    end else begin
      strobe_meta_reg <= {CS_N, WR_N, RD_N};
      strobe_sync_reg <= strobe_meta_reg;
      strobe_prev_reg <= strobe_sync_reg;
      data_meta_reg <= SHARED_DATA_LINES_IN;
      data_sync_reg <= data_meta_reg;
      chan_meta_reg <= ANALOG_INPUT_CHANNELS;
      chan_sync_reg <= chan_meta_reg;
      gnd_meta_reg <= ANALOG_GROUND;
      gnd_sync_reg <= gnd_meta_reg;
    end
  end

  // ****************************************************************
  // Strobe decoding
  // ****************************************************************
  wire cs_low = !strobe_sync_reg.cs_n;
  wire rd_low = !strobe_sync_reg.rd_n;
  wire wr_low = !strobe_sync_reg.wr_n;
  logic rd_held_reg;
  wire wr_fall = cs_low && wr_low && strobe_prev_reg.wr_n;
  wire wr_rise = cs_low && !wr_low && !strobe_prev_reg.wr_n;
  wire read_act = cs_low && rd_low;
  wire [4:0] channel_select_lines = data_sync_reg[adc_ctrl_pkg::LATCH_BITS-1:0];
  // Sampling at the rising edge relies on the host's data hold past that edge.
  wire latch_load = wr_rise && !rd_low && !rd_held_reg;

  // ****************************************************************
  // Channel latch and multiplexer
  // ****************************************************************
  logic [4:0] chan_latch_reg;
  wire rd_held_next = wr_fall ? rd_low : ((wr_low && !rd_low) ? 1'b0 : rd_held_reg);
  wire adc_ctrl_pkg::mux_sel_type mux_sel = decode_mux(chan_latch_reg);
  wire [7:0] pos_code = pick_code(mux_sel.pos_src, chan_sync_reg, gnd_sync_reg);
  wire [7:0] neg_code = pick_code(mux_sel.neg_src, chan_sync_reg, gnd_sync_reg);
  wire [4:0] latch_next = latch_load ? channel_select_lines : chan_latch_reg;

  // The new code reaches the mux one cycle after the edge, so the start waits a cycle.
  logic start_reg;

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      chan_latch_reg <= adc_ctrl_pkg::LATCH_RESET;
      rd_held_reg <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      chan_latch_reg <= latch_next;
      rd_held_reg <= rd_held_next;
      start_reg <= wr_rise;
    end
  end

  // ****************************************************************
  // Converter core
  // ****************************************************************
  logic conv_busy;
  logic conv_done;
  logic [7:0] conv_result;

  sar_engine #(
    .STEP_CYCLES(STEP_CYCLES),
    .BITS(adc_ctrl_pkg::SAR_BITS)
  ) u_sar (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .start(start_reg),
    .abort(wr_fall),
    .pos_code(pos_code),
    .neg_code(neg_code),
    .busy(conv_busy),
    .done(conv_done),
    .result(conv_result)
  );

  // ****************************************************************
  // Output latch, done flag and data drive
  // ****************************************************************
  // Done wins over a clear in the same cycle, so no finished result is lost.
  wire done_n_next = conv_done ? 1'b0 : ((wr_fall || read_act) ? 1'b1 : CONVERSION_DONE_N);
  wire [7:0] result_next = conv_done ? conv_result : SHARED_DATA_LINES_OUT;

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      CONVERSION_DONE_N <= 1'b1;
      SHARED_DATA_LINES_OUT <= adc_ctrl_pkg::RESULT_RESET;
      SHARED_DATA_LINES_OE <= 1'b0;
    end else begin
      CONVERSION_DONE_N <= done_n_next;
      SHARED_DATA_LINES_OUT <= result_next;
      SHARED_DATA_LINES_OE <= read_act;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);

  sequence s_write_end;
    wr_rise ##1 start_reg;
  endsequence

  a_start_write: assert property (s_write_end |=> conv_busy)
    else $error("Write strobe with chip select did not start a conversion.");
  a_start_cause: assert property ($rose(conv_busy) |-> $past(wr_rise, 2))
    else $error("Conversion started without a write strobe.");
  a_flag_held: assert property (!CONVERSION_DONE_N && !wr_fall && !read_act |=> !CONVERSION_DONE_N)
    else $error("Done flag rose before the result was read.");
  a_wr_release: assert property (wr_fall && !conv_done |=> CONVERSION_DONE_N && !conv_busy)
    else $error("Falling write edge did not release the done flag.");
  a_latch_load: assert property (wr_rise && !rd_low && !rd_held_reg |=> chan_latch_reg == $past(data_sync_reg[4:0]))
    else $error("Rising write edge did not load the channel latch.");
  a_latch_kept: assert property (wr_rise && rd_held_reg |=> $stable(chan_latch_reg))
    else $error("Read held low did not keep the channel latch.");
  a_done_flag: assert property (conv_done |=> !CONVERSION_DONE_N && SHARED_DATA_LINES_OUT == $past(conv_result))
    else $error("Finished conversion did not latch and flag its result.");
  a_read_drive: assert property (read_act && !conv_done |=> CONVERSION_DONE_N && SHARED_DATA_LINES_OE)
    else $error("Read did not release the flag and drive the data.");
  a_drive_only_read: assert property (SHARED_DATA_LINES_OE |-> $past(read_act))
    else $error("Data lines driven outside a read.");
  a_combined_old: assert property (read_act && wr_low && !conv_done |=> $stable(SHARED_DATA_LINES_OUT))
    else $error("Combined access did not drive the previous result.");
  a_mode_pick: assert property (!chan_latch_reg[2] |-> mux_sel.mode == adc_ctrl_pkg::MODE_DIFF)
    else $error("Mode decode wrong for differential code.");
  a_single_gnd: assert property (mux_sel.mode == adc_ctrl_pkg::MODE_SINGLE |-> neg_code == gnd_sync_reg)
    else $error("Single-ended mode not referenced to analog ground.");
  a_pseudo_ref: assert property (mux_sel.mode == adc_ctrl_pkg::MODE_PSEUDO |-> neg_code == chan_sync_reg[31:24])
    else $error("Pseudo-differential mode not referenced to the last channel.");
endmodule

// ---- pkg/adc_ctrl_pkg.sv ----
// Purpose: Shared constants and types for the converter bus control block.
// Assumes: A 200 MHz reference clock.
// Notes: Every timing count is derived from its time in printed units.
package adc_ctrl_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned CONV_TIME_US = 40;
  // The longest conversion time rounds down to whole cycles.
  localparam int unsigned CONV_CYCLES = (CONV_TIME_US * 1000 * 1000) / CLK_PERIOD_PS;
  localparam int unsigned READ_WAIT_NS = 600;
  // The least wait before a read rounds up to whole cycles.
  localparam int unsigned READ_WAIT_CYCLES = (READ_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ****************************************************************
  // Widths, fields and reset values
  // ****************************************************************
  localparam int unsigned SAR_BITS = 8;
  localparam int unsigned LATCH_BITS = 5;
  localparam int unsigned CHANNELS = 4;
  localparam int unsigned SEL_SWAP_BIT = 0;
  localparam int unsigned SEL_PAIR_BIT = 1;
  localparam int unsigned SEL_MODE_BIT = 2;
  localparam int unsigned SEL_PSEUDO_BIT = 3;
  localparam logic [4:0] LATCH_RESET = 5'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [2:0] SRC_GROUND = 3'h4;
  localparam logic [2:0] PSEUDO_REF_CH = 3'h3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_DIFF = 3'b001,
    MODE_SINGLE = 3'b010,
    MODE_PSEUDO = 3'b100
  } mux_mode_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_type;

  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
  } strobe_type;

  typedef struct packed {
    mux_mode_type mode;
    logic [2:0] pos_src;
    logic [2:0] neg_src;
  } mux_sel_type;
endpackage

// ---- design/sar_engine.sv ----
// Purpose: Successive-approximation sequencer with sample hold of both inputs.
// Assumes: Input codes stand for the selected positive and negative voltages.
// Notes: One bit is decided every STEP_CYCLES clocks, most significant first.
`timescale 1ns/1ps
module sar_engine #(
  parameter int unsigned STEP_CYCLES = 1000,
  parameter int unsigned BITS = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  input wire logic [BITS-1:0] pos_code,
  input wire logic [BITS-1:0] neg_code,
  output logic busy,
  output logic done,
  output logic [BITS-1:0] result
);
  localparam int unsigned CW = $clog2(STEP_CYCLES) + 1;

  adc_ctrl_pkg::conv_state_type state_reg;
  logic [BITS-1:0] pos_hold_reg;
  logic [BITS-1:0] neg_hold_reg;
  logic [BITS-1:0] approx_reg;
  logic [BITS-1:0] mask_reg;
  logic [CW-1:0] step_reg;
  logic done_reg;
  wire [BITS-1:0] diff;
  wire [BITS-1:0] trial;
  wire keep;

  // ****************************************************************
  // Comparison
  // ****************************************************************
  // A negative input at or above the positive one gives a zero difference.
  assign diff = (pos_hold_reg > neg_hold_reg) ? BITS'(pos_hold_reg - neg_hold_reg) : '0;
  assign trial = approx_reg | mask_reg;
  assign keep = (diff >= trial);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // A new start restarts at once, so a stale sequence never leaks a result.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= adc_ctrl_pkg::ST_IDLE;
      pos_hold_reg <= '0;
      neg_hold_reg <= '0;
      approx_reg <= '0;
      mask_reg <= '0;
      step_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (start) begin
        state_reg <= adc_ctrl_pkg::ST_CONVERT;
        pos_hold_reg <= pos_code;
        neg_hold_reg <= neg_code;
        approx_reg <= '0;
        mask_reg <= {1'b1, {(BITS-1){1'b0}}};
        step_reg <= CW'(STEP_CYCLES - 1);
      end else begin
        case (state_reg)
          adc_ctrl_pkg::ST_IDLE: begin
            state_reg <= adc_ctrl_pkg::ST_IDLE;
          end
          adc_ctrl_pkg::ST_CONVERT: begin
            if (abort) begin
              state_reg <= adc_ctrl_pkg::ST_IDLE;
            end else if (step_reg == '0) begin
              approx_reg <= keep ? trial : approx_reg;
              mask_reg <= mask_reg >> 1;
              step_reg <= CW'(STEP_CYCLES - 1);
              if (mask_reg[0]) begin
                state_reg <= adc_ctrl_pkg::ST_IDLE;
                done_reg <= 1'b1;
              end
            end else begin
              step_reg <= step_reg - 1'b1;
            end
          end
          default: begin
            state_reg <= adc_ctrl_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  assign busy = (state_reg == adc_ctrl_pkg::ST_CONVERT);
  assign done = done_reg;
  assign result = approx_reg;

  a_zero_code: assert property (@(posedge clk) disable iff (rst)
    done |-> (pos_hold_reg > neg_hold_reg) || (result == '0))
    else $error("Negative input at or above positive did not give zero.");
endmodule

// ---- test/bus_host_model.sv ----
// Purpose: Host bus model that drives the converter's strobes and shared data lines.
// Assumes: Strobe levels are held at least four cycles so the synchroniser sees each one.
// Notes: Released data lines show the inverse of their last value each cycle.
`timescale 1ns/1ps
module bus_host_model (
  input wire logic clk,
  input wire logic done_n,
  input wire logic dev_oe,
  input wire logic [7:0] dev_data,
  output adc_ctrl_pkg::strobe_type strb,
  output logic [7:0] bus
);
  // ****************************************************************
  // Bus lines and read spacing
  // ****************************************************************
  logic [7:0] wdata = 8'h00;
  logic drive = 1'b0;
  logic [7:0] last = 8'h00;
  int unsigned since_fall = 1000;

  initial strb = 3'b111;
  // A released line toggles, so a stale value can never pass for data.
  assign bus = dev_oe ? dev_data : (drive ? wdata : ~last);

  always @(posedge clk) begin
    last <= bus;
    if (done_n) begin
      since_fall <= 0;
    end else if (since_fall < 1000) begin
      since_fall <= since_fall + 1;
    end
  end

  task automatic wr(input logic [4:0] code, input logic cs_n, input logic rd_n);
    @(posedge clk);
    strb <= '{cs_n, 1'b0, rd_n};
    wdata <= {3'h5, code};
    drive <= rd_n;
    repeat (4) @(posedge clk);
    strb.wr_n <= 1'b1;
    repeat (4) @(posedge clk);
    strb <= 3'b111;
    drive <= 1'b0;
  endtask

  task automatic rd();
    while (!done_n && since_fall < adc_ctrl_pkg::READ_WAIT_CYCLES) @(posedge clk);
    @(posedge clk);
    strb <= '{1'b0, 1'b1, 1'b0};
    repeat (6) @(posedge clk);
    strb <= 3'b111;
  endtask
endmodule

// ---- test/tb.sv ----
// Purpose: Self-checking bench for the converter bus control block.
// Assumes: The block runs with a shortened conversion count of 80 cycles.
// Notes: Read data is compared by a monitor against a queue of expected results.
`timescale 1ns/1ps
`define CHK(act, exp) begin num_checks++; if ((act) !== (exp)) begin n_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (act), (exp)); end end
module tb;
  // ****************************************************************
  // Signals and helpers
  // ****************************************************************
  localparam int unsigned CONV = 80;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] chans = 32'h0;
  logic [7:0] gnd = 8'h00;
  logic [7:0] dout;
  logic [7:0] bus;
  logic oe;
  logic done_n;
  adc_ctrl_pkg::strobe_type strb;
  int n_errors = 0;
  int num_checks = 0;
  logic [7:0] exp_q[$];
  logic [7:0] exp_v;
  logic oe_q = 1'b0;
  logic [4:0] cfg = 5'h00;
  logic [7:0] last_res = 8'h00;
  logic [4:0] codes[14] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
                            5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h15, 5'h16};

  always #2.5 ref_clk = ~ref_clk;

  bus_host_model host_u (.clk(ref_clk), .done_n(done_n), .dev_oe(oe), .dev_data(dout),
    .strb(strb), .bus(bus));

  adc_bus_control #(.CONV_CYCLES(CONV)) dut_u (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
    .CS_N(strb.cs_n), .WR_N(strb.wr_n), .RD_N(strb.rd_n), .SHARED_DATA_LINES_IN(bus),
    .SHARED_DATA_LINES_OUT(dout), .SHARED_DATA_LINES_OE(oe), .CONVERSION_DONE_N(done_n),
    .ANALOG_INPUT_CHANNELS(chans), .ANALOG_GROUND(gnd));

  function automatic logic [7:0] expect_res(input logic [4:0] c, input logic [31:0] ch,
                                            input logic [7:0] g);
    int p;
    int n;
    logic [7:0] pv;
    logic [7:0] nv;
    p = c[2] ? int'(c[1:0]) : 2 * int'(c[1]) + int'(c[0]);
    n = 2 * int'(c[1]) + 1 - int'(c[0]);
    pv = ch[8*p +: 8];
    nv = c[2] ? (c[3] ? ch[31:24] : g) : ch[8*n +: 8];
    return (pv > nv) ? pv - nv : 8'h00;
  endfunction

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic convert(input logic [4:0] code, input logic rd_n);
    logic [31:0] c;
    logic [7:0] g;
    int n;
    c = $urandom();
    g = 8'($urandom());
    @(posedge ref_clk);
    chans <= c;
    gnd <= g;
    if (!rd_n) exp_q.push_back(last_res);
    host_u.wr(code, 1'b0, rd_n);
    `CHK(done_n, 1'b1)
    if (rd_n) cfg = code;
    last_res = expect_res(cfg, c, g);
    n = 0;
    while (done_n !== 1'b0 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    `CHK(1'(n <= CONV + 8), 1'b1)
    repeat (100) @(posedge ref_clk);
    `CHK(done_n, 1'b0)
    exp_q.push_back(last_res);
    host_u.rd();
    repeat (5) @(posedge ref_clk);
    `CHK(done_n, 1'b1)
    `CHK(oe, 1'b0)
  endtask

  // ****************************************************************
  // Monitor, watchdog and test sequence
  // ****************************************************************
  always @(posedge ref_clk) begin
    oe_q <= oe;
    if (oe === 1'b1 && oe_q !== 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("ERROR t=%0t got %h exp %h", $time, bus, 8'h00);
      end else begin
        exp_v = exp_q.pop_front();
        `CHK(bus, exp_v)
      end
    end
  end

  initial begin
    #100000;
    n_errors++;
    $display("ERROR t=%0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    void'($urandom(32'h8c3b));
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    `CHK(done_n, 1'b1)
    `CHK(oe, 1'b0)
    foreach (codes[i]) convert(codes[i], 1'b1);
    $display("test mux modes done");
    // The combined access also reloads nothing, so the old mode converts again.
    convert(5'h0a, 1'b0);
    $display("test combined access done");
    host_u.wr(5'h04, 1'b1, 1'b1);
    repeat (150) @(posedge ref_clk);
    `CHK(done_n, 1'b1)
    convert(5'h00, 1'b0);
    $display("test deselected write done");
    `CHK(32'(exp_q.size()), 32'h0)
    stop_test();
  end
endmodule
